// ### core/tos_core.sv
// thermal overload output stage: thresholds, trip delay, blocking check,
// condition and load codes, AHB-Lite register slave
// assumes thermal image and blocking matrix logic run on core_clk
//
// Notes on behaviour
// - outputs follow thermal capacity only
// - first alarm at enabled level, default 40
// - second alarm at own level, default 40
// - trip delayed by settable 5 ms steps
// - alarms direct, trip passes blocking check
// - blocking sampled each program cycle start
// - unblocked pick-up raises start, begins timing
// - blocked pick-up raises blocked, stops processing
// - blocking clears start, releases like reset
// - blocking issues display and blocking events
// - condition code 0 to 5 reported
// - load code 0 below 1 percent
// - load code 3 for normal load
// - load codes 2 overload, 1 high overload
// - bad service factor flagged, uses 1.0
// - bad ambient settings flagged, uses 1.0
// - bad nominal calculation flagged, uses 1.0
// - inconsistent ambient k flagged while present
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module tos_core
    import tos_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // thermal image
    input wire logic [LVL_W-1:0] thermalCap,
    input wire logic [CUR_W-1:0] measCurrent,
    input wire logic [CUR_W-1:0] pickupCurrent,
    // settings checked by the thermal image
    input wire logic [FAC_W-1:0] serviceFactorSet,
    input wire logic serviceFactorBad,
    input wire logic [FAC_W-1:0] ambientCorrSet,
    input wire logic ambientBad,
    input wire logic [FAC_W-1:0] nominalCalcSet,
    input wire logic nominalBad,
    input wire logic ambientKBad,
    // blocking matrix
    input wire logic blockIn,
    // binary outputs
    output logic alarm1Out,
    output logic alarm2Out,
    output logic inhibitOut,
    output logic tripOut,
    output logic startOut,
    output logic blockedOut,
    // events and status
    output logic displayEvent,
    output logic blockEvent,
    output logic [CUR_W-1:0] eventCurrent,
    output logic [1:0] eventFaultType,
    output logic [2:0] operatingConditionCode,
    output logic [1:0] loadCode,
    output logic [FAC_W-1:0] usedServiceFactor,
    output logic [FAC_W-1:0] usedAmbientCorr,
    output logic [FAC_W-1:0] usedNominalCalc,
    output logic [3:0] settingFault
);
    typedef struct packed {
        // settings
        logic [3:0] enable;
        logic [LVL_W-1:0] alarm1Lvl;
        logic [LVL_W-1:0] alarm2Lvl;
        logic [LVL_W-1:0] inhibitLvl;
        logic [LVL_W-1:0] tripLvl;
        logic [DLY_W-1:0] tripDelay;
        // protection state
        tos_trip_t trip;
        logic [DLY_W-1:0] delayCnt;
        logic blockSeen;
        logic alarm1;
        logic alarm2;
        logic inhibit;
        // registered output levels
        logic tripOn;
        logic startOn;
        logic blockedOn;
        logic [2:0] cond;
        logic dispEv;
        logic blockEv;
        logic [CUR_W-1:0] evCurrent;
        logic [1:0] evFault;
        // bus
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] rdata;
        logic resp;
        logic readyOut;
    } tos_core_state_t;

    localparam tos_core_state_t RESET_STATE = '{
        enable: RST_ENABLE,
        alarm1Lvl: RST_ALARM1_LVL,
        alarm2Lvl: RST_ALARM2_LVL,
        inhibitLvl: RST_INHIBIT_LVL,
        tripLvl: RST_TRIP_LVL,
        tripDelay: RST_TRIP_DELAY,
        trip: TS_IDLE,
        delayCnt: 20'h00000,
        blockSeen: 1'b0,
        alarm1: 1'b0,
        alarm2: 1'b0,
        inhibit: 1'b0,
        tripOn: 1'b0,
        startOn: 1'b0,
        blockedOn: 1'b0,
        cond: COND_NORMAL,
        dispEv: 1'b0,
        blockEv: 1'b0,
        evCurrent: 16'h0000,
        evFault: 2'h0,
        wrPend: 1'b0,
        wrAddr: 8'h00,
        rdata: 32'h00000000,
        resp: 1'b0,
        readyOut: 1'b1
    };

    tos_core_state_t state_ff;
    tos_core_state_t nxt_state;
    logic tick;
    logic pickup;
    logic [DLY_W-1:0] cntNext;
    logic addrPhase;
    logic [31:0] readMux;

    tos_cycle_tick #(
        .CYCLES(PROG_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(tick)
    );

    tos_status_guard u_guard (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .measCurrent(measCurrent),
        .pickupCurrent(pickupCurrent),
        .serviceFactorSet(serviceFactorSet),
        .serviceFactorBad(serviceFactorBad),
        .ambientCorrSet(ambientCorrSet),
        .ambientBad(ambientBad),
        .nominalCalcSet(nominalCalcSet),
        .nominalBad(nominalBad),
        .ambientKBad(ambientKBad),
        .loadCode(loadCode),
        .usedServiceFactor(usedServiceFactor),
        .usedAmbientCorr(usedAmbientCorr),
        .usedNominalCalc(usedNominalCalc),
        .settingFault(settingFault)
    );

    // only the thermal capacity decides pick-up
    assign pickup = tos_reached(thermalCap, state_ff.tripLvl,
                                state_ff.enable[EN_TRIP]);
    assign cntNext = state_ff.delayCnt + 20'h00001;
    assign addrPhase = hsel && htrans[1] && hready;

    // read view; reserved bits read as zero
    always_comb begin
        readMux = 32'h00000000;
        case (haddr[7:0])
            ADDR_CTRL: readMux[3:0] = state_ff.enable;
            ADDR_ALARM1_LVL: readMux[LVL_W-1:0] = state_ff.alarm1Lvl;
            ADDR_ALARM2_LVL: readMux[LVL_W-1:0] = state_ff.alarm2Lvl;
            ADDR_INHIBIT_LVL: readMux[LVL_W-1:0] = state_ff.inhibitLvl;
            ADDR_TRIP_LVL: readMux[LVL_W-1:0] = state_ff.tripLvl;
            ADDR_TRIP_DELAY: readMux[DLY_W-1:0] = state_ff.tripDelay;
            ADDR_STATUS: readMux[15:0] = {settingFault, loadCode,
                state_ff.cond, state_ff.blockSeen,
                state_ff.trip == TS_BLOCKED,
                (state_ff.trip == TS_TIMING) || (state_ff.trip == TS_TRIPPED),
                state_ff.trip == TS_TRIPPED, state_ff.inhibit,
                state_ff.alarm2, state_ff.alarm1};
            ADDR_EVENT: readMux[17:0] = {state_ff.evFault, state_ff.evCurrent};
            ADDR_FACTORS: readMux[29:0] = {usedNominalCalc, usedAmbientCorr,
                                           usedServiceFactor};
            default: readMux = 32'h00000000;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.dispEv = 1'b0;
        nxt_state.blockEv = 1'b0;
        nxt_state.readyOut = 1'b1;
        nxt_state.resp = 1'b0;

        // data phase of a write; unmapped and read-only offsets ignore it
        if (state_ff.wrPend) begin
            case (state_ff.wrAddr)
                ADDR_CTRL: nxt_state.enable = hwdata[3:0];
                ADDR_ALARM1_LVL: nxt_state.alarm1Lvl = hwdata[LVL_W-1:0];
                ADDR_ALARM2_LVL: nxt_state.alarm2Lvl = hwdata[LVL_W-1:0];
                ADDR_INHIBIT_LVL: nxt_state.inhibitLvl = hwdata[LVL_W-1:0];
                ADDR_TRIP_LVL: nxt_state.tripLvl = hwdata[LVL_W-1:0];
                ADDR_TRIP_DELAY: nxt_state.tripDelay = hwdata[DLY_W-1:0];
                default: nxt_state.enable = state_ff.enable;
            endcase
        end
        // address phase: capture write, or load read data for next cycle
        nxt_state.wrPend = addrPhase && hwrite;
        nxt_state.wrAddr = {haddr[7:2], 2'b00};
        if (addrPhase && !hwrite) begin
            nxt_state.rdata = readMux;
        end

        if (tick) begin
            // blocking is taken once, at the head of the cycle
            nxt_state.blockSeen = blockIn;
            // alarm and inhibit act directly, never blocked
            nxt_state.alarm1 = tos_reached(thermalCap, state_ff.alarm1Lvl,
                state_ff.enable[EN_ALARM1]);
            nxt_state.alarm2 = tos_reached(thermalCap, state_ff.alarm2Lvl,
                state_ff.enable[EN_ALARM2]);
            nxt_state.inhibit = tos_reached(thermalCap, state_ff.inhibitLvl,
                state_ff.enable[EN_INHIBIT]);

            case (state_ff.trip)
                TS_IDLE: begin
                    nxt_state.delayCnt = 20'h00000;
                    if (pickup && blockIn) begin
                        nxt_state.trip = TS_BLOCKED;
                    end else if (pickup) begin
                        // zero delay trips in the same cycle as start
                        if (state_ff.tripDelay == 20'h00000) begin
                            nxt_state.trip = TS_TRIPPED;
                        end else begin
                            nxt_state.trip = TS_TIMING;
                        end
                    end
                end
                TS_TIMING: begin
                    if (!pickup) begin
                        nxt_state.trip = TS_IDLE;
                    end else if (blockIn) begin
                        // start drops and timing released as on reset
                        nxt_state.trip = TS_BLOCKED;
                        nxt_state.delayCnt = 20'h00000;
                    end else begin
                        nxt_state.delayCnt = cntNext;
                        if (cntNext >= state_ff.tripDelay) begin
                            nxt_state.trip = TS_TRIPPED;
                        end
                    end
                end
                TS_TRIPPED: begin
                    if (!pickup) begin
                        nxt_state.trip = TS_IDLE;
                    end else if (blockIn) begin
                        nxt_state.trip = TS_BLOCKED;
                    end
                end
                TS_BLOCKED: begin
                    // held until pick-up or blocking goes away
                    if (!pickup || !blockIn) begin
                        nxt_state.trip = TS_IDLE;
                    end
                    nxt_state.delayCnt = 20'h00000;
                end
                default: nxt_state.trip = TS_IDLE;
            endcase

            // pins come straight from flops
            nxt_state.tripOn = nxt_state.trip == TS_TRIPPED;
            nxt_state.startOn = (nxt_state.trip == TS_TIMING) ||
                                (nxt_state.trip == TS_TRIPPED);
            nxt_state.blockedOn = nxt_state.trip == TS_BLOCKED;

            // events on entry to blocked carry current and load class
            if ((nxt_state.trip == TS_BLOCKED) &&
                (state_ff.trip != TS_BLOCKED)) begin
                nxt_state.dispEv = 1'b1;
                nxt_state.blockEv = 1'b1;
                nxt_state.evCurrent = measCurrent;
                nxt_state.evFault = loadCode;
            end

            // most severe state wins the condition code
            if (nxt_state.trip == TS_BLOCKED) begin
                nxt_state.cond = COND_BLOCKED;
            end else if (nxt_state.trip == TS_TRIPPED) begin
                nxt_state.cond = COND_TRIP;
            end else if (nxt_state.inhibit) begin
                nxt_state.cond = COND_INHIBIT;
            end else if (nxt_state.alarm2) begin
                nxt_state.cond = COND_ALARM2;
            end else if (nxt_state.alarm1) begin
                nxt_state.cond = COND_ALARM1;
            end else begin
                nxt_state.cond = COND_NORMAL;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // bus answers are always zero-wait and OKAY
    assign hreadyout = state_ff.readyOut;
    assign hresp = state_ff.resp;
    assign hrdata = state_ff.rdata;
    assign alarm1Out = state_ff.alarm1;
    assign alarm2Out = state_ff.alarm2;
    assign inhibitOut = state_ff.inhibit;
    assign tripOut = state_ff.tripOn;
    assign startOut = state_ff.startOn;
    assign blockedOut = state_ff.blockedOn;
    assign displayEvent = state_ff.dispEv;
    assign blockEvent = state_ff.blockEv;
    assign eventCurrent = state_ff.evCurrent;
    assign eventFaultType = state_ff.evFault;
    assign operatingConditionCode = state_ff.cond;
endmodule

// ### core/tos_pkg.sv
// constants, codes and register map of the thermal overload output stage
// assumes one 10 MHz clock and word-aligned AHB-Lite register access
package tos_pkg;
    // clock and program cycle
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned PROG_CYCLE_US = 5000;
    localparam int unsigned PROG_CYCLE_CYC =
        CLK_HZ / 1_000_000 * PROG_CYCLE_US;
    // trip delay step equals one program cycle
    localparam int unsigned TRIP_STEP_US = 5000;
    localparam int unsigned TRIP_STEP_CYCLES = TRIP_STEP_US / PROG_CYCLE_US;

    // field widths
    localparam int LVL_W = 11;
    localparam int DLY_W = 20;
    localparam int CUR_W = 16;
    localparam int FAC_W = 10;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ALARM1_LVL = 8'h04;
    localparam logic [7:0] ADDR_ALARM2_LVL = 8'h08;
    localparam logic [7:0] ADDR_INHIBIT_LVL = 8'h0c;
    localparam logic [7:0] ADDR_TRIP_LVL = 8'h10;
    localparam logic [7:0] ADDR_TRIP_DELAY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_EVENT = 8'h1c;
    localparam logic [7:0] ADDR_FACTORS = 8'h20;

    // enable bit positions in the control register
    localparam int EN_ALARM1 = 0;
    localparam int EN_ALARM2 = 1;
    localparam int EN_INHIBIT = 2;
    localparam int EN_TRIP = 3;

    // reset values, levels in 0.1 % of thermal capacity
    localparam logic [3:0] RST_ENABLE = 4'h0;
    localparam logic [LVL_W-1:0] RST_ALARM1_LVL = 11'h190;
    localparam logic [LVL_W-1:0] RST_ALARM2_LVL = 11'h190;
    localparam logic [LVL_W-1:0] RST_INHIBIT_LVL = 11'h320;
    localparam logic [LVL_W-1:0] RST_TRIP_LVL = 11'h3e8;
    localparam logic [DLY_W-1:0] RST_TRIP_DELAY = 20'h00000;

    // operating condition codes
    localparam logic [2:0] COND_NORMAL = 3'h0;
    localparam logic [2:0] COND_ALARM1 = 3'h1;
    localparam logic [2:0] COND_ALARM2 = 3'h2;
    localparam logic [2:0] COND_INHIBIT = 3'h3;
    localparam logic [2:0] COND_TRIP = 3'h4;
    localparam logic [2:0] COND_BLOCKED = 3'h5;

    // load status codes, currents in 0.001 x nominal
    localparam logic [1:0] LOAD_LIGHT = 2'h0;
    localparam logic [1:0] LOAD_HIGH = 2'h1;
    localparam logic [1:0] LOAD_OVER = 2'h2;
    localparam logic [1:0] LOAD_NORMAL = 2'h3;
    localparam logic [CUR_W-1:0] LIGHT_LIMIT = 16'h000a;
    localparam logic [CUR_W-1:0] TWICE_NOMINAL = 16'h07d0;

    // factor 1.0 in steps of 0.01
    localparam logic [FAC_W-1:0] FACTOR_ONE = 10'h064;

    // trip path states
    typedef enum logic [1:0] {
        TS_IDLE = 2'b00,
        TS_TIMING = 2'b01,
        TS_TRIPPED = 2'b10,
        TS_BLOCKED = 2'b11
    } tos_trip_t;

    // threshold reached: equal counts, disabled never reaches
    function automatic logic tos_reached(input logic [LVL_W-1:0] cap,
                                         input logic [LVL_W-1:0] lvl,
                                         input logic en);
        return en && (cap >= lvl);
    endfunction
endpackage

// ### core/tos_cycle_tick.sv
// program cycle divider: one-cycle pulse every CYCLES clocks
// assumes a synchronous active-high reset on the same clock
`timescale 1ns/100ps
module tos_cycle_tick
    import tos_pkg::*;
#(
    parameter int unsigned CYCLES = PROG_CYCLE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // program cycle pulse
    output logic tick
);
    typedef struct packed {
        logic [23:0] count;
        logic tick;
    } tos_tick_state_t;

    localparam logic [23:0] LAST = 24'(CYCLES - 1);

    tos_tick_state_t state_ff;
    tos_tick_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (state_ff.count >= LAST) begin
            nxt_state.count = 24'h000000;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.count = state_ff.count + 24'h000001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tick = state_ff.tick;
endmodule

// ### core/tos_status_guard.sv
// load status classification and setting-fault substitution
// assumes inputs come from logic on core_clk; load code updated on each program tick, factors and flags on every clock
`timescale 1ns/100ps
module tos_status_guard
    import tos_pkg::*;
(
    // clock, reset, program cycle
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic tick,
    // currents from the thermal image
    input wire logic [CUR_W-1:0] measCurrent,
    input wire logic [CUR_W-1:0] pickupCurrent,
    // settings and their validity
    input wire logic [FAC_W-1:0] serviceFactorSet,
    input wire logic serviceFactorBad,
    input wire logic [FAC_W-1:0] ambientCorrSet,
    input wire logic ambientBad,
    input wire logic [FAC_W-1:0] nominalCalcSet,
    input wire logic nominalBad,
    input wire logic ambientKBad,
    // results
    output logic [1:0] loadCode,
    output logic [FAC_W-1:0] usedServiceFactor,
    output logic [FAC_W-1:0] usedAmbientCorr,
    output logic [FAC_W-1:0] usedNominalCalc,
    output logic [3:0] settingFault
);
    typedef struct packed {
        logic [1:0] load;
        logic [FAC_W-1:0] sf;
        logic [FAC_W-1:0] amb;
        logic [FAC_W-1:0] nom;
        logic [3:0] fault;
    } tos_guard_state_t;

    tos_guard_state_t state_ff;
    tos_guard_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (tick) begin
            // light band wins, then high overload, then overloading
            if (measCurrent < LIGHT_LIMIT) begin
                nxt_state.load = LOAD_LIGHT;
            end else if (measCurrent > TWICE_NOMINAL) begin
                nxt_state.load = LOAD_HIGH;
            end else if (measCurrent > pickupCurrent) begin
                nxt_state.load = LOAD_OVER;
            end else begin
                nxt_state.load = LOAD_NORMAL;
            end
        end
        // flags follow the fault directly, shown only while it lasts
        nxt_state.sf = serviceFactorBad ? FACTOR_ONE
                                        : serviceFactorSet;
        nxt_state.amb = ambientBad ? FACTOR_ONE : ambientCorrSet;
        nxt_state.nom = nominalBad ? FACTOR_ONE : nominalCalcSet;
        nxt_state.fault = {ambientKBad, nominalBad, ambientBad,
                           serviceFactorBad};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= {LOAD_LIGHT, FACTOR_ONE, FACTOR_ONE, FACTOR_ONE, 4'h0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign loadCode = state_ff.load;
    assign usedServiceFactor = state_ff.sf;
    assign usedAmbientCorr = state_ff.amb;
    assign usedNominalCalc = state_ff.nom;
    assign settingFault = state_ff.fault;
endmodule

// ### sim/tos_core_assertions.sv
// port checker for tos_core, bound below the module
// assumes one clock and synchronous active-high sys_rst
`timescale 1ns/100ps
module tos_core_assertions
    import tos_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // watched inputs
    input wire logic [CUR_W-1:0] measCurrent,
    input wire logic serviceFactorBad,
    input wire logic ambientBad,
    input wire logic nominalBad,
    input wire logic ambientKBad,
    // watched outputs
    input wire logic alarm1Out,
    input wire logic tripOut,
    input wire logic startOut,
    input wire logic blockedOut,
    input wire logic displayEvent,
    input wire logic blockEvent,
    input wire logic [CUR_W-1:0] eventCurrent,
    input wire logic [2:0] operatingConditionCode,
    input wire logic [FAC_W-1:0] usedServiceFactor,
    input wire logic [3:0] settingFault
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic [2:0] cond = operatingConditionCode;
    sequence s_blkEnter;
        !blockedOut ##1 blockedOut;
    endsequence
    property p_blkEvt;
        s_blkEnter |-> displayEvent && blockEvent
            && eventCurrent == $past(measCurrent);
    endproperty
    a_blkEvt: assert property (p_blkEvt) else $error("blk evt");
    property p_evtPulse;
        displayEvent || blockEvent |=> !(displayEvent || blockEvent);
    endproperty
    a_evtPulse: assert property (p_evtPulse) else $error("evt len");
    property p_blkOnly;
        blockedOut |-> cond == COND_BLOCKED && !startOut && !tripOut;
    endproperty
    a_blkOnly: assert property (p_blkOnly) else $error("blk");
    property p_trip;
        tripOut |-> startOut && cond == COND_TRIP;
    endproperty
    a_trip: assert property (p_trip) else $error("trip");
    property p_normal;
        cond == COND_NORMAL |-> !(alarm1Out || tripOut || blockedOut);
    endproperty
    a_normal: assert property (p_normal) else $error("normal");
    property p_alarm1;
        cond == COND_ALARM1 |-> alarm1Out && !tripOut;
    endproperty
    a_alarm1: assert property (p_alarm1) else $error("alarm1");
    property p_flags;
        !$past(sys_rst) |-> settingFault == {$past(ambientKBad),
            $past(nominalBad), $past(ambientBad), $past(serviceFactorBad)};
    endproperty
    a_flags: assert property (p_flags) else $error("flags");
    property p_sfUse;
        settingFault[0] |-> usedServiceFactor == FACTOR_ONE;
    endproperty
    a_sfUse: assert property (p_sfUse) else $error("sf use");
endmodule
bind tos_core tos_core_assertions chk (.*);

// ### sim/tos_image_model.sv
// stand-in for the thermal image and the blocking matrix
// assumes the bench sets its commands away from the rising edge
`timescale 1ns/100ps
module tos_image_model
    import tos_pkg::*;
(
    // clock and bench commands
    input wire logic core_clk,
    input wire logic [LVL_W-1:0] capCmd,
    input wire logic [CUR_W-1:0] measCmd,
    input wire logic blockCmd,
    // towards the output stage
    output logic [LVL_W-1:0] thermalCap = 11'h000,
    output logic [CUR_W-1:0] measCurrent = 16'h0000,
    output logic blockIn = 1'b0
);
    // moves just after an edge, so no same-step race with the stage
    always @(posedge core_clk) begin
        thermalCap <= capCmd;
        measCurrent <= measCmd;
        // raised a tick or more before the delay runs out
        blockIn <= blockCmd;
    end
endmodule

// ### sim/tos_core_bench.sv
// self-checking bench for tos_core against a behavioural model
// assumes tos_image_model feeds the thermal image side
`timescale 1ns/100ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %0t %h %h", $time, g, e); end end
module tos_core_bench;
    import tos_pkg::*;
    localparam int P = 20;
    logic core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, hready;
    logic hreadyout, hresp, blockCmd = 0, blockIn;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [2:0] hsize = 3'h2, operatingConditionCode;
    logic [1:0] htrans = 0, loadCode, eventFaultType;
    logic [LVL_W-1:0] capCmd = 0, thermalCap;
    logic [CUR_W-1:0] measCmd = 0, pickupCurrent = 16'h03e8;
    logic [CUR_W-1:0] measCurrent, eventCurrent;
    logic [FAC_W-1:0] serviceFactorSet = 0, usedServiceFactor;
    logic [FAC_W-1:0] ambientCorrSet = 10'h050, usedAmbientCorr;
    logic [FAC_W-1:0] nominalCalcSet = 10'h06e, usedNominalCalc;
    logic serviceFactorBad = 0, ambientBad = 0, nominalBad = 0;
    logic ambientKBad = 0, alarm1Out, alarm2Out, inhibitOut, tripOut;
    logic startOut, blockedOut, displayEvent, blockEvent;
    logic [3:0] settingFault;
    logic [15:0] seed = 16'h63f4;
    wire logic [2:0] flags = {blockedOut, tripOut, startOut};
    int lvl[4], mTab[8] = '{9, 10, 1000, 1001, 2000, 2001, 0, 500};
    int dTab[2] = '{0, 3}, en, c, n, miscompares = 0, nTests = 0;
    assign hready = hreadyout;
    tos_image_model img (.*);
    tos_core #(.PROG_CYCLES(P)) dut (.*);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [2:0] cdExp(int cap);
        for (int i = 2; i >= 0; i--)
            if (en[i] && cap >= lvl[i])
                return 3'(i + 1);
        return COND_NORMAL;
    endfunction
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic settle(int cyc);
        repeat (cyc) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic waitFor(int w);
        n = 0;
        while (flags[w] !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task automatic reportAndStop;
        if (miscompares == 0 && nTests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial forever #50 core_clk = ~core_clk;
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        reportAndStop();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 0;
        lvl = '{400, 400, 800, 1000};
        en = 0;
        for (int i = 0; i < 6; i++) begin
            bus(0, 8'(4 * i), 0);
            `CHK(rd, 32'(i == 0 ? en : i < 5 ? lvl[i - 1] : 0))
        end
        bus(0, 8'h40, 0);
        `CHK({hresp, rd}, 33'h0)
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 3; i++) begin
                seed = lfsr(seed);
                lvl[i] = seed % 1001;
                bus(1, 8'(4 * i + 4), 32'(lvl[i]));
            end
            seed = lfsr(seed);
            en = seed[2:0];
            bus(1, ADDR_CTRL, 32'(en));
            c = lvl[k % 3] + seed[4:3] - 1;
            if (c < 0)
                c = 0;
            capCmd <= 11'(c);
            measCmd <= 16'(mTab[k]);
            serviceFactorSet <= seed[15:6];
            {ambientKBad, nominalBad} <= seed[8:7];
            {ambientBad, serviceFactorBad} <= seed[6:5];
            settle(3 * P);
            `CHK(alarm1Out, en[0] && c >= lvl[0])
            `CHK(alarm2Out, en[1] && c >= lvl[1])
            `CHK(inhibitOut, en[2] && c >= lvl[2])
            `CHK(operatingConditionCode, cdExp(c))
            c = mTab[k] < 10 ? 0 : mTab[k] > 2000 ? 1 :
                mTab[k] > 1000 ? 2 : 3;
            `CHK(loadCode, 2'(c))
            `CHK(settingFault, seed[8:5])
            `CHK(usedServiceFactor,
                 seed[5] ? FACTOR_ONE : seed[15:6])
            `CHK(usedAmbientCorr, seed[6] ? FACTOR_ONE : 10'h050)
            `CHK(usedNominalCalc, seed[7] ? FACTOR_ONE : 10'h06e)
        end
        capCmd <= 0;
        foreach (dTab[j]) begin
            bus(1, ADDR_TRIP_DELAY, 32'(dTab[j]));
            bus(1, ADDR_CTRL, 32'h8);
            capCmd <= 11'h3e8;
            waitFor(0);
            waitFor(1);
            `CHK(n, dTab[j] * P)
            `CHK(operatingConditionCode, COND_TRIP)
            capCmd <= 0;
            settle(3 * P);
            `CHK({tripOut, startOut}, 2'h0)
        end
        bus(1, ADDR_TRIP_DELAY, 32'h4);
        capCmd <= 11'h3e8;
        waitFor(0);
        blockCmd <= 1;
        waitFor(2);
        `CHK({tripOut, startOut}, 2'h0)
        `CHK(operatingConditionCode, COND_BLOCKED)
        `CHK(eventCurrent, measCmd)
        `CHK(eventFaultType, LOAD_NORMAL)
        blockCmd <= 0;
        waitFor(0);
        `CHK(startOut, 1'b1)
        capCmd <= 0;
        blockCmd <= 1;
        settle(3 * P);
        capCmd <= 11'h3e8;
        settle(3 * P);
        `CHK({blockedOut, startOut}, 2'h2)
        reportAndStop();
    end
endmodule
